// ### hdl/rtc_pkg.sv
// Shared constants, types and reset values of the clock control block
//
// How it works
// - Oscillator disable bit, zero runs, resets zero
// - Rate bits pick 1Hz/4k/8k/32k square wave
// - Both rate bits reset to one
// - Route set sends alarms to separate pins
// - Route clear puts square wave on shared
// - Alarm2 enable gates alarm2 onto routed pin
// - Alarm1 enable gates alarm1 onto first pin
// - Interrupt pins pull low while flag enabled
// - Oscillator stop of any kind sets flag
// - Oscillator flag holds until written zero
// - Alarm flags clear only by writing zero
// - Slave only, up to 400kHz bus clock
// - Transfers begin only from idle bus
// - Data edges with clock high frame transfers
// - Data stable while clock high, bit per pulse
// - Receiver pulls data low in ninth clock
// - Master nack ends read, slave releases data
// - Bytes travel most significant bit first
// - Master sets length; repeated start keeps bus
// - Write: address, then data bytes, each acked
// - Read: slave sends bytes until master nacks
// - Answer address 1101000, direction bit follows
// - First written byte sets pointer, then increments
// - Read starts at the remembered pointer
// - Alarm flags set only at second update
package rtc_pkg;

  localparam logic [3:0] CTRL_ADDR     = 4'he;
  localparam logic [3:0] STAT_ADDR     = 4'hf;
  localparam logic [6:0] SLAVE_ADDR    = 7'h68;

  localparam int         OSC_DIS_BIT   = 7;
  localparam int         RATE_HI_BIT   = 4;
  localparam int         RATE_LO_BIT   = 3;
  localparam int         ROUTE_BIT     = 2;
  localparam int         ALARM2_IRQ_ENABLE_BIT      = 1;
  localparam int         ALARM1_IRQ_ENABLE_BIT      = 0;
  localparam int         OSF_BIT       = 7;
  localparam int         A2F_BIT       = 1;
  localparam int         A1F_BIT       = 0;

  localparam logic [7:0] CTRL_RESET    = 8'h18;
  localparam logic [7:0] STAT_RESET    = 8'h80;
  localparam logic [7:0] CTRL_WMASK    = 8'h9f;
  localparam logic [7:0] STAT_MASK     = 8'h83;

  // Oscillator clock runs at twice the fastest square-wave rate
  localparam int         OSC_HZ        = 65536;
  localparam int         DIV_WIDTH     = 16;
  localparam logic [3:0] TAP_1HZ       = 4'hf;
  localparam logic [3:0] TAP_4K        = 4'h3;
  localparam logic [3:0] TAP_8K        = 4'h2;
  localparam logic [3:0] TAP_32K       = 4'h0;

  localparam int         CORE_HZ       = 100000000;
  localparam int         SCL_MAX_HZ    = 400000;
  localparam int         SCL_HALF_CYC  = CORE_HZ / (2 * SCL_MAX_HZ);

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} linkState_e;

  typedef struct packed {
    logic out;
    logic oe;
  } odPin_s;

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic       sclPrev;
    logic       sdaPrev;
    logic [1:0] sqSync;
    linkState_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic       isAddr;
    logic       isPtr;
    logic       rd;
    logic       ackd;
    logic [3:0] ptr;
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic       oscOn;
    odPin_s     sda;
    odPin_s     irqA;
    odPin_s     irqB;
  } rtcCore_s;

  localparam rtcCore_s CORE_RESET = '{
    sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1, sdaPrev: 1'b1, sqSync: 2'h3,
    st: ST_IDLE, bitCnt: 4'h0, shift: 8'h00, isAddr: 1'b0, isPtr: 1'b0,
    rd: 1'b0, ackd: 1'b0, ptr: 4'h0, ctrl: CTRL_RESET, stat: STAT_RESET,
    oscOn: 1'b1, sda: 2'h0, irqA: 2'h0, irqB: 2'h0};

  typedef struct packed {
    logic [1:0]           rstSync;
    logic [1:0]           runSync;
    logic [1:0]           rateHiSync;
    logic [1:0]           rateLoSync;
    logic [DIV_WIDTH-1:0] div;
    logic                 sq;
  } sqGen_s;

endpackage : rtc_pkg

// ### hdl/sq_wave_gen.sv
// Square-wave divider running on the oscillator clock
module sq_wave_gen (
  input  wire logic       oscClk,
  input  wire logic       reset,
  input  wire logic       oscOn,
  input  wire logic [1:0] rateSel,
  output logic            sqWave
);

  rtc_pkg::sqGen_s q;
  rtc_pkg::sqGen_s n;
  logic            oscReset;
  logic [3:0]      tap;

  assign oscReset = q.rstSync[1];

  always_comb begin
    n            = q;
    n.rstSync    = {q.rstSync[0], reset};
    n.runSync    = {q.runSync[0], oscOn};
    n.rateHiSync = {q.rateHiSync[0], rateSel[1]};
    n.rateLoSync = {q.rateLoSync[0], rateSel[0]};
    case ({q.rateHiSync[1], q.rateLoSync[1]})
      2'h0:    tap = rtc_pkg::TAP_1HZ;
      2'h1:    tap = rtc_pkg::TAP_4K;
      2'h2:    tap = rtc_pkg::TAP_8K;
      default: tap = rtc_pkg::TAP_32K;
    endcase
    // Counter freezes while the oscillator is disabled
    if (q.runSync[1]) begin
      n.div = q.div + 16'h0001;
    end
    n.sq = q.div[tap];
    if (oscReset) begin
      n.runSync    = 2'h0;
      n.rateHiSync = 2'h3;
      n.rateLoSync = 2'h3;
      n.div        = 16'h0000;
      n.sq         = 1'b0;
    end
  end

  always_ff @(posedge oscClk) begin
    q <= n;
  end

  assign sqWave = q.sq;

endmodule : sq_wave_gen

// ### hdl/rtc_ctrl_i2c_slave.sv
// Control/status registers of the clock block behind a two-wire bus slave
module rtc_ctrl_i2c_slave (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       oscClk,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic       secondTick,
  input  wire logic       alarm1Match,
  input  wire logic       alarm2Match,
  input  wire logic       oscStopEvent,
  output rtc_pkg::odPin_s sdaPin,
  output rtc_pkg::odPin_s irqANPin,
  output rtc_pkg::odPin_s sqwaveIrqBNPin,
  output logic            oscEnable
);

  rtc_pkg::rtcCore_s q;
  rtc_pkg::rtcCore_s n;

  logic       sclS;
  logic       sdaS;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       wrStrobe;
  logic       addrMiss;
  logic       a1Irq;
  logic       a2Irq;
  logic       sqWave;
  logic [7:0] rdData;

  sq_wave_gen u_sq_wave_gen (
    .oscClk  (oscClk),
    .reset   (reset),
    .oscOn   (q.oscOn),
    .rateSel ({q.ctrl[rtc_pkg::RATE_HI_BIT], q.ctrl[rtc_pkg::RATE_LO_BIT]}),
    .sqWave  (sqWave)
  );

  // Only the second sync stage and its delayed copy feed edge detection
  assign sclS      = q.sclSync[1];
  assign sdaS      = q.sdaSync[1];
  assign sclRise   = sclS & ~q.sclPrev;
  assign sclFall   = ~sclS & q.sclPrev;
  assign startCond = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
  assign stopCond  = sclS & q.sclPrev & ~q.sdaPrev & sdaS;

  // Pointers outside control and status read zero here
  function automatic logic [7:0] readReg(input logic [3:0] ptr,
                                         input logic [7:0] ctrl,
                                         input logic [7:0] stat);
    logic [7:0] val;
    val = 8'h00;
    if (ptr == rtc_pkg::CTRL_ADDR) begin
      val = ctrl & rtc_pkg::CTRL_WMASK;
    end else if (ptr == rtc_pkg::STAT_ADDR) begin
      val = stat & rtc_pkg::STAT_MASK;
    end
    return val;
  endfunction : readReg

  assign rdData = readReg(q.ptr, q.ctrl, q.stat);

  always_comb begin
    n         = q;
    wrStrobe  = 1'b0;
    addrMiss  = 1'b0;
    // Oversampling at core rate leaves ample margin for fast-mode bus clocks
    n.sclSync = {q.sclSync[0], sclIn};
    n.sdaSync = {q.sdaSync[0], sdaIn};
    n.sclPrev = q.sclSync[1];
    n.sdaPrev = q.sdaSync[1];
    n.sqSync  = {q.sqSync[0], sqWave};

    // Start wins at any time: a repeated start re-arms without a release
    if (stopCond) begin
      n.st     = rtc_pkg::ST_IDLE;
      n.sda.oe = 1'b0;
    end else if (startCond) begin
      n.st     = rtc_pkg::ST_RX;
      n.bitCnt = 4'h0;
      n.isAddr = 1'b1;
      n.isPtr  = 1'b0;
      n.sda.oe = 1'b0;
    end else begin
      case (q.st)
        rtc_pkg::ST_IDLE: begin
          n.sda.oe = 1'b0;
        end
        rtc_pkg::ST_RX: begin
          if (sclRise && q.bitCnt != 4'h8) begin
            n.shift  = {q.shift[6:0], sdaS};
            n.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == 4'h8) begin
            n.isAddr = 1'b0;
            if (q.isAddr) begin
              if (q.shift[7:1] == rtc_pkg::SLAVE_ADDR) begin
                n.rd     = q.shift[0];
                n.isPtr  = ~q.shift[0];
                n.sda.oe = 1'b1;
                n.st     = rtc_pkg::ST_RX_ACK;
              end else begin
                addrMiss = 1'b1;
                n.st     = rtc_pkg::ST_IDLE;
              end
            end else begin
              n.sda.oe = 1'b1;
              n.st     = rtc_pkg::ST_RX_ACK;
              n.isPtr  = 1'b0;
              if (q.isPtr) begin
                n.ptr = q.shift[3:0];
              end else begin
                wrStrobe = 1'b1;
                n.ptr    = q.ptr + 4'h1;
              end
            end
          end
        end
        rtc_pkg::ST_RX_ACK: begin
          if (sclFall) begin
            n.bitCnt = 4'h0;
            if (q.rd) begin
              n.shift  = rdData;
              n.ptr    = q.ptr + 4'h1;
              n.sda.oe = ~rdData[7];
              n.st     = rtc_pkg::ST_TX;
            end else begin
              n.sda.oe = 1'b0;
              n.st     = rtc_pkg::ST_RX;
            end
          end
        end
        rtc_pkg::ST_TX: begin
          // Data changes only after the clock has fallen
          if (sclFall) begin
            if (q.bitCnt == 4'h7) begin
              n.sda.oe = 1'b0;
              n.st     = rtc_pkg::ST_TX_ACK;
            end else begin
              n.bitCnt = q.bitCnt + 4'h1;
              n.shift  = {q.shift[6:0], 1'b0};
              n.sda.oe = ~q.shift[6];
            end
          end
        end
        rtc_pkg::ST_TX_ACK: begin
          if (sclRise) begin
            n.ackd = ~sdaS;
          end else if (sclFall) begin
            if (q.ackd) begin
              n.bitCnt = 4'h0;
              n.shift  = rdData;
              n.ptr    = q.ptr + 4'h1;
              n.sda.oe = ~rdData[7];
              n.st     = rtc_pkg::ST_TX;
            end else begin
              n.sda.oe = 1'b0;
              n.st     = rtc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          n.st     = rtc_pkg::ST_IDLE;
          n.sda.oe = 1'b0;
        end
      endcase
    end

    // Register writes land on the falling edge before the ack bit
    if (wrStrobe && q.ptr == rtc_pkg::CTRL_ADDR) begin
      n.ctrl = q.shift & rtc_pkg::CTRL_WMASK;
    end
    n.stat = q.stat & rtc_pkg::STAT_MASK;
    if (wrStrobe && q.ptr == rtc_pkg::STAT_ADDR) begin
      n.stat = q.stat & q.shift & rtc_pkg::STAT_MASK;
    end
    // Hardware set beats a software clear in the same cycle
    if (oscStopEvent || q.ctrl[rtc_pkg::OSC_DIS_BIT]) begin
      n.stat[rtc_pkg::OSF_BIT] = 1'b1;
    end
    if (alarm1Match && secondTick) begin
      n.stat[rtc_pkg::A1F_BIT] = 1'b1;
    end
    if (alarm2Match && secondTick) begin
      n.stat[rtc_pkg::A2F_BIT] = 1'b1;
    end

    n.oscOn    = ~q.ctrl[rtc_pkg::OSC_DIS_BIT];
    a1Irq      = q.stat[rtc_pkg::A1F_BIT] & q.ctrl[rtc_pkg::ALARM1_IRQ_ENABLE_BIT];
    a2Irq      = q.stat[rtc_pkg::A2F_BIT] & q.ctrl[rtc_pkg::ALARM2_IRQ_ENABLE_BIT];
    n.irqA.oe  = a1Irq | (a2Irq & ~q.ctrl[rtc_pkg::ROUTE_BIT]);
    n.irqA.out = 1'b0;
    n.irqB.out = 1'b0;
    n.sda.out  = 1'b0;
    if (q.ctrl[rtc_pkg::ROUTE_BIT]) begin
      n.irqB.oe = a2Irq;
    end else begin
      n.irqB.oe = ~q.sqSync[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= rtc_pkg::CORE_RESET;
    end else begin
      q <= n;
    end
  end

  assign sdaPin         = q.sda;
  assign irqANPin       = q.irqA;
  assign sqwaveIrqBNPin = q.irqB;
  assign oscEnable      = q.oscOn;

  default clocking cb @(posedge core_clk);
  endclocking

  sequence byteEnd;
    q.st == rtc_pkg::ST_RX && q.bitCnt == 4'h8 && sclFall && !startCond && !stopCond;
  endsequence

  sequence nackSeen;
    q.st == rtc_pkg::ST_TX_ACK && !q.ackd && sclFall && !startCond && !stopCond;
  endsequence

  chk_reset_osc_run: assert property (reset |=> !q.ctrl[7] && oscEnable)
    else $error("oscillator not enabled after reset");

  chk_reset_rate_bits: assert property (reset |=> q.ctrl[4:3] == 2'h3 && !q.ctrl[2])
    else $error("rate or route bits wrong after reset");

  chk_alarm1_pin: assert property (disable iff (reset)
    q.stat[0] && q.ctrl[0] |=> irqANPin.oe && !irqANPin.out)
    else $error("alarm 1 did not pull the first pin low");

  chk_route_alarm2: assert property (disable iff (reset)
    q.stat[1] && q.ctrl[1] && q.ctrl[2] |=> sqwaveIrqBNPin.oe)
    else $error("routed alarm 2 missing on shared pin");

  chk_square_out: assert property (disable iff (reset)
    !q.ctrl[2] && q.sqSync[1] |=> !sqwaveIrqBNPin.oe)
    else $error("shared pin pulled low while square wave high");

  chk_osf_hold: assert property (disable iff (reset)
    q.stat[7] && !(wrStrobe && q.ptr == 4'hf && !q.shift[7]) |=> q.stat[7])
    else $error("oscillator flag dropped without a zero write");

  chk_alarm_tick: assert property (disable iff (reset)
    !q.stat[0] && !(alarm1Match && secondTick) |=> !q.stat[0])
    else $error("alarm 1 flag set outside a second update");

  chk_ack_drive: assert property (disable iff (reset)
    byteEnd ##0 !addrMiss |=> sdaPin.oe && q.st == rtc_pkg::ST_RX_ACK)
    else $error("received byte not acknowledged");

  chk_addr_miss: assert property (disable iff (reset)
    addrMiss |=> (!sdaPin.oe && q.st == rtc_pkg::ST_IDLE) [*2])
    else $error("foreign address acknowledged");

  chk_nack_release: assert property (disable iff (reset)
    nackSeen |=> !sdaPin.oe && q.st == rtc_pkg::ST_IDLE)
    else $error("data line held after master not-acknowledge");

  chk_start_arm: assert property (disable iff (reset)
    startCond |=> q.st == rtc_pkg::ST_RX && q.bitCnt == 4'h0 && q.isAddr)
    else $error("start condition did not arm address reception");

  sequence ackFallRead;
    q.st == rtc_pkg::ST_RX_ACK && q.rd && sclFall && !startCond && !stopCond;
  endsequence

  chk_osc_follow: assert property (disable iff (reset)
    q.ctrl[7] |=> !oscEnable)
    else $error("oscillator still enabled while disabled in control");

  chk_alarm2_first: assert property (disable iff (reset)
    q.stat[1] && q.ctrl[1] && !q.ctrl[2] |=> irqANPin.oe)
    else $error("alarm 2 missing on first pin with route clear");

  chk_alarm1_gate: assert property (disable iff (reset)
    !q.ctrl[0] && !(q.stat[1] && q.ctrl[1] && !q.ctrl[2]) |=> !irqANPin.oe)
    else $error("first pin pulled low without an enabled alarm");

  chk_osf_event: assert property (disable iff (reset)
    oscStopEvent || q.ctrl[7] |=> q.stat[7])
    else $error("oscillator stop did not set its flag");

  chk_alarm_keep: assert property (disable iff (reset)
    q.stat[0] && !(wrStrobe && q.ptr == 4'hf && !q.shift[0]) |=> q.stat[0])
    else $error("alarm 1 flag dropped without a zero write");

  chk_unused_zero: assert property (disable iff (reset)
    q.ctrl[6:5] == 2'h0 && q.stat[6:2] == 5'h00)
    else $error("unused register bits not zero");

  chk_ptr_load: assert property (disable iff (reset)
    byteEnd ##0 q.isPtr |=> q.ptr == $past(q.shift[3:0]))
    else $error("pointer byte not loaded");

  chk_tx_first: assert property (disable iff (reset)
    ackFallRead |=> sdaPin.oe == !$past(rdData[7]) && q.st == rtc_pkg::ST_TX)
    else $error("first read bit not driven from the pointed register");

  chk_pins_low: assert property (disable iff (reset)
    !sdaPin.out && !irqANPin.out && !sqwaveIrqBNPin.out)
    else $error("open-drain pin driving high");

endmodule : rtc_ctrl_i2c_slave

// ### tb/i2c_master_model.sv
// Two-wire bus master model stepping on the core clock
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter bit in core cycles; well above fast mode to keep the run short
  localparam int QTR = 10;

  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic step();
    repeat (QTR) @(posedge clk);
    #1;
  endtask : step

  // Also serves as repeated start while the clock is low
  task automatic start();
    sdaDrv = 1'b1;
    step();
    scl = 1'b1;
    step();
    sdaDrv = 1'b0;
    step();
    scl = 1'b0;
    step();
  endtask : start

  task automatic stop();
    sdaDrv = 1'b0;
    step();
    scl = 1'b1;
    step();
    sdaDrv = 1'b1;
    step();
  endtask : stop

  task automatic bitIo(input logic b, output logic s);
    sdaDrv = b;
    step();
    scl = 1'b1;
    step();
    s = sdaLine;
    step();
    scl = 1'b0;
    step();
  endtask : bitIo

  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask : writeByte

  task automatic readByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(last, s);
  endtask : readByte
endmodule : i2c_master_model

// ### tb/tb_top.sv
// Self-checking bench for the clock control block and its bus slave
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic            core_clk = 1'b0;
  logic            oscClk   = 1'b0;
  logic            reset;
  logic            secondTick;
  logic            alarm1Match;
  logic            alarm2Match;
  logic            oscStopEvent;
  logic            scl;
  logic            sdaDrv;
  rtc_pkg::odPin_s sdaPin;
  rtc_pkg::odPin_s irqANPin;
  rtc_pkg::odPin_s sqwaveIrqBNPin;
  logic            oscEnable;
  logic [7:0]      ctrlExp;
  logic [7:0]      statExp;
  logic [15:0]     rq = 16'hac97;
  logic            ack;
  logic [7:0]      rd;
  int              errors = 0;
  int              comparisons = 0;
  int              n;
  // Pull-up on the data wire
  wire logic       sdaLine = sdaDrv & ~(sdaPin.oe & ~sdaPin.out);

  initial forever #5 core_clk = ~core_clk;
  initial begin
    #7;
    forever #32 oscClk = ~oscClk;
  end

  rtc_ctrl_i2c_slave u_dut (.core_clk(core_clk), .reset(reset), .oscClk(oscClk), .sclIn(scl),
    .sdaIn(sdaLine), .secondTick(secondTick), .alarm1Match(alarm1Match),
    .alarm2Match(alarm2Match), .oscStopEvent(oscStopEvent), .sdaPin(sdaPin),
    .irqANPin(irqANPin), .sqwaveIrqBNPin(sqwaveIrqBNPin), .oscEnable(oscEnable));
  i2c_master_model u_master (.clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

  function automatic logic [15:0] lfsrNext(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsrNext

  function automatic logic [7:0] statNext(input logic [7:0] s, input logic [7:0] w,
                                          input logic [7:0] c);
    return {s[7] & w[7] | c[7], 5'h00, s[1:0] & w[1:0]};
  endfunction : statNext

  function automatic logic irqAExp(input logic [7:0] c, input logic [7:0] s);
    return s[0] & c[0] | s[1] & c[1] & !c[2];
  endfunction : irqAExp

  // Edges in 20 us with a 64 ns oscillator period
  function automatic int sqEdges(input logic [1:0] r);
    case (r)
      2'h0: return 0;
      2'h1: return 39;
      2'h2: return 78;
      default: return 312;
    endcase
  endfunction : sqEdges

  task automatic summarize();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wb(input logic [7:0] d);
    u_master.writeByte(d, ack);
    check("ack", 8'h01, {7'h00, ack});
  endtask : wb

  task automatic regWrite2(input logic [7:0] c, input logic [7:0] s);
    u_master.start();
    wb(8'hd0);
    wb(8'h0e);
    wb(c);
    wb(s);
    u_master.stop();
    ctrlExp = c & 8'h9f;
    statExp = statNext(statExp, s, ctrlExp);
  endtask : regWrite2

  task automatic regRead2();
    u_master.start();
    wb(8'hd0);
    wb(8'h0e);
    u_master.start();
    wb(8'hd1);
    u_master.readByte(1'b0, rd);
    check("ctrl", ctrlExp, rd);
    u_master.readByte(1'b1, rd);
    check("stat", statExp, rd);
    u_master.stop();
  endtask : regRead2

  task automatic pins();
    check("irqA", {7'h00, irqAExp(ctrlExp, statExp)}, {7'h00, irqANPin.oe});
    if (ctrlExp[2]) check("irqB", {7'h00, statExp[1] & ctrlExp[1]}, {7'h00, sqwaveIrqBNPin.oe});
    check("oscEn", {7'h00, !ctrlExp[7]}, {7'h00, oscEnable});
  endtask : pins

  task automatic pulse(input logic t, input logic m1, input logic m2, input logic os);
    alarm1Match  = m1;
    alarm2Match  = m2;
    secondTick   = t;
    oscStopEvent = os;
    @(posedge core_clk);
    #1;
    secondTick   = 1'b0;
    oscStopEvent = 1'b0;
    if (t) statExp[1:0] = statExp[1:0] | {m2, m1};
    if (os) statExp[7] = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : pulse

  initial begin
    reset = 1'b1;
    pulse(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    ctrlExp = 8'h18;
    statExp = 8'h80;
    regRead2();
    pins();
    u_master.start();
    u_master.writeByte(8'ha0, ack);
    check("nack", 8'h00, {7'h00, ack});
    u_master.stop();
    regWrite2(8'h05, 8'h00);
    // Pointer wrapped past status to an empty place
    u_master.start();
    wb(8'hd1);
    u_master.readByte(1'b1, rd);
    check("wrap", 8'h00, rd);
    u_master.stop();
    u_master.start();
    wb(8'hd0);
    wb(8'h0f);
    u_master.stop();
    u_master.start();
    wb(8'hd1);
    u_master.readByte(1'b1, rd);
    check("ptr", statExp, rd);
    u_master.stop();
    for (int i = 0; i < 10; i++) begin
      rq = lfsrNext(rq);
      pulse(rq[0], rq[1], rq[2], rq[3] & rq[4]);
      rq = lfsrNext(rq);
      regWrite2({rq[7] & rq[9], rq[14:8]}, rq[7:0] | 8'h7c);
      pins();
      regRead2();
    end
    pulse(1'b1, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      regWrite2({3'h0, 2'h3, k[2:0]}, 8'hff);
      pins();
    end
    for (int r = 0; r < 4; r++) begin
      regWrite2({3'h0, r[1:0], 3'h0}, 8'h00);
      pins();
      n = 0;
      repeat (2000) begin
        rd[0] = sqwaveIrqBNPin.oe;
        @(posedge core_clk);
        #1;
        if (sqwaveIrqBNPin.oe !== rd[0]) n++;
      end
      check("sqEdges", 8'h01, {7'h00, n + 3 >= sqEdges(r[1:0]) && n <= sqEdges(r[1:0]) + 3});
    end
    regRead2();
    summarize();
  end

  initial begin
    // Roughly a third again the expected length of all scenarios
    #900000;
    errors++;
    summarize();
  end
endmodule : tb_top
